// [css_clock_control.sv]
// Clock source select, start-up timing and clock domain gating.
// Assumes one 200 MHz clk_sys; oscillator and watchdog ticks arrive as one-cycle enables.
`include "css_map.svh"

module css_clock_control (
	// Clock and reset
	input  wire logic               clk_sys,
	input  wire logic               reset_n,
	// Fuse fields, unprogrammed bits read 1
	input  wire css_pkg::css_fuse_t fuse,
	// Source and watchdog oscillator ticks, one cycle each
	input  wire logic               osc_tick,
	input  wire logic               wdog_tick,
	input  wire logic               async_xtal_tick,
	// Sleep requests
	input  wire logic               sleep_req,
	input  wire logic               sleep_deep,
	input  wire logic               sleep_core,
	input  wire logic               sleep_periph,
	input  wire logic               sleep_converter,
	input  wire logic               wake_req,
	// Asynchronous wake sources seen while peripheral clock stops
	input  wire logic               async_int_pending,
	input  wire logic               two_wire_addr_match,
	// Gated clock enables
	output css_pkg::css_gate_t      gate_q,
	// Status
	output css_pkg::css_src_t       source_q,
	output logic [2:0]              band_q,
	output logic                    full_swing_q,
	output logic                    core_ready_q,
	output logic                    cfg_reserved_q
);

	////////////////////////////////////////////////////////////////////////////
	// Fuse decode

	css_pkg::css_cfg_t cfg;

	css_fuse_decode u_decode (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.fuse    (fuse),
		.cfg_q   (cfg)
	);

	function automatic logic [16:0] dly_count(input css_pkg::css_dly_t d);
		case (d)
			css_pkg::DLY_4K:  dly_count = `CSS_WDOG_4K;
			css_pkg::DLY_64K: dly_count = `CSS_WDOG_64K;
			default:          dly_count = 17'h0_0000;
		endcase
	endfunction : dly_count

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	css_pkg::css_state_t state_q, state_d;
	logic [16:0]         cnt_q, cnt_d;
	logic                cfg_vld_q, cfg_vld_d;
	logic                deep_q, deep_d;
	logic                wake_any;

	// Async interrupt and address match wake even with peripheral clock off
	assign wake_any = wake_req | async_int_pending | two_wire_addr_match;

	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		cfg_vld_d = 1'b1;
		deep_d    = deep_q;
		case (state_q)
			css_pkg::ST_RESET: begin
				// Wait one cycle for the registered decode
				if (cfg_vld_q) begin
					state_d = css_pkg::ST_OSC;
					cnt_d   = cfg.osc_cycles;
				end
			end
			css_pkg::ST_OSC: begin
				if (cnt_q == 17'h0_0000) begin
					if (deep_q) begin
						state_d = css_pkg::ST_RUN;
						deep_d  = 1'b0;
					end else if (cfg.dly == css_pkg::DLY_NONE) begin
						state_d = css_pkg::ST_RUN;
					end else begin
						state_d = css_pkg::ST_DELAY;
						cnt_d   = dly_count(cfg.dly);
					end
				end else if (osc_tick) begin
					cnt_d = cnt_q - 17'h0_0001;
				end
			end
			css_pkg::ST_DELAY: begin
				if (cnt_q == 17'h0_0000) begin
					state_d = css_pkg::ST_RUN;
				end else if (wdog_tick) begin
					cnt_d = cnt_q - 17'h0_0001;
				end
			end
			css_pkg::ST_RUN: begin
				if (sleep_req) begin
					state_d = css_pkg::ST_SLEEP;
					deep_d  = sleep_deep;
				end
			end
			css_pkg::ST_SLEEP: begin
				if (wake_any) begin
					state_d = css_pkg::ST_WAKE;
				end
			end
			css_pkg::ST_WAKE: begin
				if (deep_q) begin
					// Oscillator was stopped: time its restart
					state_d = css_pkg::ST_OSC;
					cnt_d   = cfg.osc_cycles;
				end else begin
					state_d = css_pkg::ST_RUN;
				end
			end
			default: begin
				state_d = css_pkg::ST_RESET;
				cnt_d   = 17'h0_0000;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q   <= css_pkg::ST_RESET;
			cnt_q     <= 17'h0_0000;
			cfg_vld_q <= 1'b0;
			deep_q    <= 1'b0;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			cfg_vld_q <= cfg_vld_d;
			deep_q    <= deep_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock domain gating

	css_pkg::css_gate_t gate_d;
	logic               running;
	logic               asleep;

	assign running = (state_q == css_pkg::ST_RUN);
	// Wake transit keeps sleep gating, so a running converter sees no one-cycle drop
	assign asleep  = (state_q == css_pkg::ST_SLEEP) | (state_q == css_pkg::ST_WAKE);

	function automatic logic domain_on(input logic run, input logic nap, input logic stop,
		input logic deep);
		domain_on = run | (nap & ~stop & ~deep);
	endfunction : domain_on

	always_comb begin
		// Core held off until all start-up counting ends
		gate_d.core_clock = domain_on(running, asleep, sleep_core, deep_q);
		// Program memory shares the core gate
		gate_d.program_memory_clock = gate_d.core_clock;
		gate_d.peripheral_clock     = domain_on(running, asleep, sleep_periph, deep_q);
		// Async timer always follows its own crystal, asleep or not
		gate_d.async_timer_clock    = async_xtal_tick;
		// Converter independent of core and peripheral gates
		gate_d.converter_clock      = domain_on(running, asleep, sleep_converter, deep_q);
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			gate_q <= '0;
		end else begin
			gate_q <= gate_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			source_q       <= css_pkg::SRC_XTAL;
			band_q         <= 3'h0;
			full_swing_q   <= 1'b0;
			core_ready_q   <= 1'b0;
			cfg_reserved_q <= 1'b0;
		end else begin
			source_q       <= cfg.src;
			band_q         <= cfg.band;
			full_swing_q   <= cfg.full_swing;
			core_ready_q   <= running;
			cfg_reserved_q <= cfg.reserved;
		end
	end

endmodule : css_clock_control

// [css_map.svh]
// Fuse field codes, default codes and timing counts of the clock control block.
// Assumes inclusion by the package and by the design files; definitions only.
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH

// Fuse field codes, a bit reading 1 means unprogrammed
`define CSS_SRCSEL_XTAL_LO  4'b1010
`define CSS_SRCSEL_LFXTAL   4'b1001
`define CSS_SRCSEL_ERC_LO   4'b0101
`define CSS_SRCSEL_IRC_LO   4'b0001
`define CSS_SRCSEL_EXTCLK   4'b0000
`define CSS_SRCSEL_DEFAULT  4'b0001
`define CSS_STARTSEL_DEFAULT 2'b10
`define CSS_BAND_LOW        3'b101
`define CSS_BAND_MID        3'b110
`define CSS_BAND_HIGH       3'b111

// Start-up counts in cycles of the selected source
`define CSS_CK_6            17'h0_0006
`define CSS_CK_18           17'h0_0012
`define CSS_CK_258          17'h0_0102
`define CSS_CK_1K           17'h0_0400
`define CSS_CK_16K          17'h0_4000
`define CSS_CK_32K          17'h0_8000

// Reset delay counts in watchdog oscillator cycles
`define CSS_WDOG_4K         17'h0_1000
`define CSS_WDOG_64K        17'h1_0000
`define CSS_CNT_W           17

`endif

// [css_pkg.sv]
// Types of the clock source select and start-up block.
// Assumes css_map.svh is on the include path.
`include "css_map.svh"

package css_pkg;

	typedef enum logic [2:0] {
		SRC_XTAL   = 3'h0,
		SRC_LFXTAL = 3'h1,
		SRC_ERC    = 3'h2,
		SRC_IRC    = 3'h3,
		SRC_EXTCLK = 3'h4
	} css_src_t;

	typedef enum logic [1:0] {
		DLY_NONE = 2'h0,
		DLY_4K   = 2'h1,
		DLY_64K  = 2'h2
	} css_dly_t;

	typedef enum logic [2:0] {
		ST_RESET   = 3'b000,
		ST_OSC     = 3'b001,
		ST_DELAY   = 3'b011,
		ST_RUN     = 3'b010,
		ST_SLEEP   = 3'b110,
		ST_WAKE    = 3'b111
	} css_state_t;

	typedef struct packed {
		logic [3:0] clock_source_select_fuses;
		logic [1:0] startup_time_select_fuses;
		logic       amplifier_option_fuse;
	} css_fuse_t;

	typedef struct packed {
		logic core_clock;
		logic peripheral_clock;
		logic program_memory_clock;
		logic async_timer_clock;
		logic converter_clock;
	} css_gate_t;

	typedef struct packed {
		css_src_t         src;
		logic [2:0]       band;
		logic             full_swing;
		logic             reserved;
		logic [16:0]      osc_cycles;
		css_dly_t         dly;
	} css_cfg_t;

endpackage : css_pkg

// [css_fuse_decode.sv]
// Decodes the fuse fields into source, band, amplifier mode and start-up counts.
// Assumes fuses are static after reset; output is registered.
`include "css_map.svh"

module css_fuse_decode (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             reset_n,
	// Fuses and decoded configuration
	input  wire css_pkg::css_fuse_t fuse,
	output css_pkg::css_cfg_t     cfg_q
);

	css_pkg::css_cfg_t cfg_d;

	always_comb begin
		cfg_d            = '0;
		cfg_d.band       = fuse.clock_source_select_fuses[3:1];
		cfg_d.full_swing = ~fuse.amplifier_option_fuse;
		// Source family by fuse range
		if (fuse.clock_source_select_fuses >= `CSS_SRCSEL_XTAL_LO) begin
			cfg_d.src = css_pkg::SRC_XTAL;
		end else if (fuse.clock_source_select_fuses == `CSS_SRCSEL_LFXTAL) begin
			cfg_d.src = css_pkg::SRC_LFXTAL;
		end else if (fuse.clock_source_select_fuses >= `CSS_SRCSEL_ERC_LO) begin
			cfg_d.src = css_pkg::SRC_ERC;
		end else if (fuse.clock_source_select_fuses >= `CSS_SRCSEL_IRC_LO) begin
			cfg_d.src = css_pkg::SRC_IRC;
		end else begin
			cfg_d.src = css_pkg::SRC_EXTCLK;
		end
		case (cfg_d.src)
			css_pkg::SRC_XTAL: begin
				case ({fuse.clock_source_select_fuses[0], fuse.startup_time_select_fuses})
					3'b000:  begin cfg_d.osc_cycles = `CSS_CK_258; cfg_d.dly = css_pkg::DLY_4K;   end
					3'b001:  begin cfg_d.osc_cycles = `CSS_CK_258; cfg_d.dly = css_pkg::DLY_64K;  end
					3'b010:  begin cfg_d.osc_cycles = `CSS_CK_1K;  cfg_d.dly = css_pkg::DLY_NONE; end
					3'b011:  begin cfg_d.osc_cycles = `CSS_CK_1K;  cfg_d.dly = css_pkg::DLY_4K;   end
					3'b100:  begin cfg_d.osc_cycles = `CSS_CK_1K;  cfg_d.dly = css_pkg::DLY_64K;  end
					3'b101:  begin cfg_d.osc_cycles = `CSS_CK_16K; cfg_d.dly = css_pkg::DLY_NONE; end
					3'b110:  begin cfg_d.osc_cycles = `CSS_CK_16K; cfg_d.dly = css_pkg::DLY_4K;   end
					default: begin cfg_d.osc_cycles = `CSS_CK_16K; cfg_d.dly = css_pkg::DLY_64K;  end
				endcase
			end
			css_pkg::SRC_LFXTAL: begin
				cfg_d.osc_cycles = (fuse.startup_time_select_fuses == 2'b10) ? `CSS_CK_32K : `CSS_CK_1K;
				cfg_d.dly        = (fuse.startup_time_select_fuses == 2'b00) ? css_pkg::DLY_4K
				                                                             : css_pkg::DLY_64K;
				cfg_d.reserved   = (fuse.startup_time_select_fuses == 2'b11);
			end
			css_pkg::SRC_ERC: begin
				cfg_d.osc_cycles = (fuse.startup_time_select_fuses == 2'b11) ? `CSS_CK_6 : `CSS_CK_18;
				case (fuse.startup_time_select_fuses)
					2'b00:   cfg_d.dly = css_pkg::DLY_NONE;
					2'b10:   cfg_d.dly = css_pkg::DLY_64K;
					default: cfg_d.dly = css_pkg::DLY_4K;
				endcase
			end
			default: begin
				// Internal RC and external clock share the six-cycle start-up
				cfg_d.osc_cycles = `CSS_CK_6;
				case (fuse.startup_time_select_fuses)
					2'b00:   cfg_d.dly = css_pkg::DLY_NONE;
					2'b01:   cfg_d.dly = css_pkg::DLY_4K;
					default: cfg_d.dly = css_pkg::DLY_64K;
				endcase
				cfg_d.reserved = (fuse.startup_time_select_fuses == 2'b11);
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cfg_q <= '0;
		end else begin
			cfg_q <= cfg_d;
		end
	end

endmodule : css_fuse_decode

// [css_osc_model.sv]
// Far-side oscillators: source, watchdog and 32 kHz crystal ticks.
// Assumes the bench loads a burst only while the model is idle.
module css_osc_model (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        reset_n,
	// Burst control
	input wire logic        load_osc,
	input wire logic        load_wdog,
	input wire logic [16:0] n,
	input wire logic [1:0]  gap,
	// Ticks
	output logic            osc_tick = 1'b0,
	output logic            wdog_tick = 1'b0,
	output logic            async_xtal_tick = 1'b0,
	output logic            idle
);
	logic [16:0] osc_left = 17'h0_0000;
	logic [16:0] wdog_left = 17'h0_0000;
	logic [1:0]  wait_q = 2'h0;
	logic [2:0]  xt_q = 3'h0;
	assign idle = osc_left == 17'h0_0000 && wdog_left == 17'h0_0000;
	// Watch crystal ignores device reset
	always @(posedge clk_sys) begin
		xt_q <= xt_q + 3'h1;
		async_xtal_tick <= xt_q == 3'h7;
	end
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			osc_left <= 17'h0_0000;
			wdog_left <= 17'h0_0000;
			wait_q <= 2'h0;
			osc_tick <= 1'b0;
			wdog_tick <= 1'b0;
		end else begin
			osc_tick <= 1'b0;
			wdog_tick <= 1'b0;
			if (load_osc)
				osc_left <= n;
			if (load_wdog)
				wdog_left <= n;
			if (wait_q != 2'h0)
				wait_q <= wait_q - 2'h1;
			else if (osc_left != 17'h0_0000) begin
				// Ceramic resonator, so short starts and band 101 are fair use
				osc_tick <= 1'b1;
				osc_left <= osc_left - 17'h0_0001;
				wait_q <= gap;
			end else if (wdog_left != 17'h0_0000) begin
				wdog_tick <= 1'b1;
				wdog_left <= wdog_left - 17'h0_0001;
				wait_q <= gap;
			end
		end
	end
endmodule : css_osc_model

// [css_clock_control_sva.sv]
// Port assertions of the clock control block.
// Assumes one clk_sys domain with asynchronous active-low reset_n.
module css_clock_control_sva (
	// Clock and reset
	input wire logic               clk_sys,
	input wire logic               reset_n,
	// Inputs
	input wire css_pkg::css_fuse_t fuse,
	input wire logic               async_xtal_tick,
	input wire logic               sleep_req,
	input wire logic               sleep_deep,
	input wire logic               sleep_core,
	input wire logic               sleep_periph,
	input wire logic               sleep_converter,
	// Outputs
	input wire css_pkg::css_gate_t gate_q,
	input wire css_pkg::css_src_t  source_q,
	input wire logic [2:0]         band_q,
	input wire logic               full_swing_q,
	input wire logic               core_ready_q
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	function automatic css_pkg::css_src_t exp_src(logic [3:0] c);
		if (c >= 4'hA) return css_pkg::SRC_XTAL;
		if (c == 4'h9) return css_pkg::SRC_LFXTAL;
		if (c >= 4'h5) return css_pkg::SRC_ERC;
		if (c != 4'h0) return css_pkg::SRC_IRC;
		return css_pkg::SRC_EXTCLK;
	endfunction : exp_src
	chk_src_decode: assert property (core_ready_q |->
		source_q == exp_src(fuse.clock_source_select_fuses)) else $error("source decode");
	chk_band_field: assert property (core_ready_q |->
		band_q == fuse.clock_source_select_fuses[3:1]) else $error("band field");
	chk_amp_mode: assert property (core_ready_q |->
		full_swing_q == !fuse.amplifier_option_fuse) else $error("amplifier mode");
	chk_flash_core: assert property (
		gate_q.program_memory_clock == gate_q.core_clock) else $error("flash gate");
	chk_core_gate: assert property (core_ready_q |-> gate_q.core_clock)
		else $error("core gate off while ready");
	chk_reset_hold: assert property ($rose(reset_n) |-> !core_ready_q [*8])
		else $error("early release");
	chk_async_run: assert property (async_xtal_tick |=> gate_q.async_timer_clock)
		else $error("async timer gate");
	chk_deep_stop: assert property (core_ready_q && sleep_req && sleep_deep |->
		##[1:3] !(gate_q.core_clock | gate_q.peripheral_clock | gate_q.converter_clock))
		else $error("deep sleep gates");
	chk_conv_keep: assert property (core_ready_q && sleep_req && !sleep_deep && sleep_core
		&& sleep_periph && !sleep_converter |-> ##[1:3] (!gate_q.core_clock
		&& !gate_q.peripheral_clock && gate_q.converter_clock)) else $error("converter gate");
endmodule : css_clock_control_sva
//////////////////////////////////////////////////////////////////////
bind css_clock_control css_clock_control_sva u_css_clock_control_sva (.clk_sys, .reset_n,
	.fuse, .async_xtal_tick, .sleep_req, .sleep_deep, .sleep_core, .sleep_periph,
	.sleep_converter, .gate_q, .source_q, .band_q, .full_swing_q, .core_ready_q);

// [testbench.sv]
// Self-checking bench: start-up counts per fuse setting, sleep and wake.
// Assumes the oscillator model drives the ticks and the checker is bound.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	css_pkg::css_fuse_t fuse = 7'h0D;
	logic [4:0] sl = 5'h00;
	logic [2:0] wk = 3'h0;
	logic load_osc = 1'b0;
	logic load_wdog = 1'b0;
	logic [16:0] n = 17'h0_0000;
	logic [1:0] gap = 2'h0;
	logic osc_tick, wdog_tick, async_xtal_tick, idle;
	logic full_swing_q, core_ready_q, cfg_reserved_q;
	logic ready_d = 1'b0;
	css_pkg::css_gate_t gate_q;
	css_pkg::css_src_t source_q;
	logic [2:0] band_q;
	logic [12:0] exp_v;
	logic [12:0] exp_q[$];
	int n_mismatch = 0;
	int n_compared = 0;
	// Cases: fuse {select, start-up, amplifier}, source, source ticks, watchdog ticks
	logic [6:0] cf[8] = '{7'h0D, 7'h55, 7'h50, 7'h7B, 7'h49, 7'h21, 7'h31, 7'h01};
	logic [2:0] cs[8] = '{3'h3, 3'h0, 3'h0, 3'h0, 3'h1, 3'h3, 3'h2, 3'h4};
	logic [16:0] co[8] = '{17'h0_0006, 17'h0_0400, 17'h0_0102, 17'h0_4000, 17'h0_0400,
		17'h0_0006, 17'h0_0012, 17'h0_0006};
	logic [16:0] cw[8] = '{17'h1_0000, 17'h0_0000, 17'h0_1000, 17'h0_0000, 17'h0_1000,
		17'h0_0000, 17'h0_0000, 17'h0_0000};
	always #2.5 clk_sys = ~clk_sys;
	css_clock_control u_css_clock_control (.clk_sys, .reset_n, .fuse, .osc_tick, .wdog_tick,
		.async_xtal_tick, .sleep_req(sl[4]), .sleep_deep(sl[3]), .sleep_core(sl[2]),
		.sleep_periph(sl[1]), .sleep_converter(sl[0]), .wake_req(wk[2]),
		.async_int_pending(wk[1]), .two_wire_addr_match(wk[0]), .gate_q, .source_q, .band_q,
		.full_swing_q, .core_ready_q, .cfg_reserved_q);
	css_osc_model u_css_osc_model (.clk_sys, .reset_n, .load_osc, .load_wdog, .n, .gap,
		.osc_tick, .wdog_tick, .async_xtal_tick, .idle);
	// A release with no note queued means the core left too early
	always @(posedge clk_sys) begin
		ready_d <= core_ready_q;
		if (core_ready_q === 1'b1 && ready_d !== 1'b1) begin
			exp_v = exp_q.size() != 0 ? exp_q.pop_front() : 13'h1FFF;
			`CHK({gate_q & 5'h1D, source_q, band_q, full_swing_q, cfg_reserved_q}, exp_v)
		end
	end
	//////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task automatic cyc(int k);
		repeat (k) @(posedge clk_sys);
	endtask : cyc
	task automatic burst(logic w, logic [16:0] k);
		int t;
		t = 0;
		load_wdog <= w;
		load_osc <= !w;
		n <= k;
		@(posedge clk_sys);
		load_wdog <= 1'b0;
		load_osc <= 1'b0;
		do begin
			@(posedge clk_sys);
			t++;
		end while (!idle && t < 70000);
		if (!idle) begin
			n_mismatch++;
			test_done();
		end
	endtask : burst
	task automatic wait_ready();
		int t;
		t = 0;
		while (core_ready_q !== 1'b1 && t < 10) begin
			@(posedge clk_sys);
			t++;
		end
		if (core_ready_q !== 1'b1) begin
			n_mismatch++;
			test_done();
		end
	endtask : wait_ready
	task automatic note(logic [2:0] src);
		exp_q.push_back({5'h1D, src, fuse.clock_source_select_fuses[3:1],
			~fuse.amplifier_option_fuse, 1'b0});
	endtask : note
	// All but the last tick, then the note, then the releasing tick
	task automatic start(logic [2:0] src, logic [16:0] oc, logic [16:0] wc);
		burst(1'b0, wc == 17'h0_0000 ? oc - 17'h0_0001 : oc);
		if (wc != 17'h0_0000)
			burst(1'b1, wc - 17'h0_0001);
		cyc(4);
		note(src);
		burst(wc != 17'h0_0000, 17'h0_0001);
		wait_ready();
	endtask : start
	task automatic sleeps();
		for (int j = 0; j < 4; j++) begin
			sl <= j < 3 ? 5'h16 : 5'h19;
			cyc(1);
			sl[4] <= 1'b0;
			cyc(4);
			`CHK(core_ready_q, 1'b0)
			if (j < 3)
				note(3'h0);
			wk <= 3'h4 >> (j % 3);
			cyc(3);
			wk <= 3'h0;
			if (j == 3)
				start(3'h0, 17'h0_0102, 17'h0_0000);
			else
				wait_ready();
		end
	endtask : sleeps
	initial begin
		void'($urandom(88));
		@(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			reset_n <= 1'b0;
			fuse <= cf[i];
			gap <= co[i] + cw[i] < 17'h0_044C ? 2'($urandom_range(0, 3)) : 2'h0;
			cyc(10);
			reset_n <= 1'b1;
			cyc(4);
			start(cs[i], co[i], cw[i]);
			if (i == 2)
				sleeps();
		end
		// Reserved start-up codes of internal RC and low-frequency crystal
		for (int r = 0; r < 2; r++) begin
			reset_n <= 1'b0;
			fuse <= r == 0 ? 7'h0F : 7'h4F;
			cyc(2);
			reset_n <= 1'b1;
			cyc(3);
			`CHK(cfg_reserved_q, 1'b1)
		end
		test_done();
	end
endmodule : testbench
